// *** pkg/ccr_consts.vh ***
`ifndef CCR_CONSTS_VH
`define CCR_CONSTS_VH

// register indices; byte address is four times the index
`define CCR_IDX_CTRL 8'h10
`define CCR_IDX_STAT 8'h11
`define CCR_IDX_A_HI 8'h13
`define CCR_IDX_A_LO 8'h14
`define CCR_IDX_B_HI 8'h15
`define CCR_IDX_B_LO 8'h16

// control register fields
`define CCR_PRESC_MSB 2
`define CCR_PRESC_LSB 0
`define CCR_PRESC_RST 3'h0

// status register fields (read clears bits 3:0)
`define CCR_ST_A_LOST 0
`define CCR_ST_B_LOST 1
`define CCR_ST_A_WRAP 2
`define CCR_ST_B_WRAP 3
`define CCR_ST_MODE 4

`define CCR_CNT_RST 16'h0000
`define CCR_BYTE_RST 8'h00

`endif

// *** verilog/ccr_prescaler.v ***
`timescale 1ns/100ps
`include "ccr_consts.vh"

module ccr_prescaler (
   input wire hclk,
   input wire hresetn,
   input wire pulse,
   input wire [2:0] setting,
   output reg tick
);
   reg [6:0] cnt;
   wire [6:0] target;

   // group of 2^setting pulses per tick
   assign target = (7'h01 << setting) - 7'h01;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 7'h00;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (pulse) begin
            if (cnt >= target) begin
               cnt <= 7'h00;
               tick <= 1'b1;
            end else begin
               cnt <= cnt + 7'h01;
            end
         end
      end
   end
endmodule

// *** verilog/ccr_counter.v ***
`timescale 1ns/100ps
`include "ccr_consts.vh"

module ccr_counter (
   input wire hclk,
   input wire hresetn,
   input wire tick,
   input wire inhibit,
   input wire capture_hi,
   output reg [15:0] count,
   output reg [7:0] shadow,
   output wire lost,
   output wire wrap
);
   // ticks during a freeze are dropped
   assign lost = tick & inhibit;
   assign wrap = tick & ~inhibit & (count == 16'hffff);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= `CCR_CNT_RST;
         shadow <= `CCR_BYTE_RST;
      end else begin
         if (tick && !inhibit) begin
            count <= count + 16'h0001;
         end
         if (capture_hi) begin
            shadow <= count[7:0];
         end
      end
   end
endmodule

// *** verilog/ccr_top.v ***
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/100ps
`include "ccr_consts.vh"

module ccr_top (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire first_converter_output_pulse,
   input wire second_converter_output_pulse,
   input wire active_energy_mode
);
   ////////////////////////////////////////////////////////////////////////////
   // address phase decode
   wire [7:0] idx;
   wire aligned;
   wire req;
   wire take;
   wire sel_a;
   wire sel_b;

   assign idx = haddr[9:2];
   assign aligned = (haddr[1:0] == 2'b00) & (haddr[31:10] == 22'h000000);
   assign req = hsel & htrans[1];
   assign take = req & hready;
   assign sel_a = aligned & ((idx == `CCR_IDX_A_HI) | (idx == `CCR_IDX_A_LO));
   assign sel_b = aligned & ((idx == `CCR_IDX_B_HI) | (idx == `CCR_IDX_B_LO));

   // zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // data phase tracking
   reg dp_a;
   reg dp_b;
   reg dp_wr_ctrl;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_a <= 1'b0;
         dp_b <= 1'b0;
         dp_wr_ctrl <= 1'b0;
      end else if (hready) begin
         // data phase ends on this edge, so freeze drops unless a new address holds it
         dp_a <= take & sel_a;
         dp_b <= take & sel_b;
         dp_wr_ctrl <= take & hwrite & aligned & (idx == `CCR_IDX_CTRL);
      end
   end

   wire inhibit_a;
   wire inhibit_b;

   // freeze from address phase through data phase of the transfer
   assign inhibit_a = (req & sel_a) | dp_a;
   assign inhibit_b = (req & sel_b) | dp_b;

   ////////////////////////////////////////////////////////////////////////////
   // control register
   reg [2:0] pulse_prescaler_setting;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pulse_prescaler_setting <= `CCR_PRESC_RST;
      end else if (dp_wr_ctrl && hready) begin
         pulse_prescaler_setting <= hwdata[`CCR_PRESC_MSB:`CCR_PRESC_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // prescalers and counters
   wire tick_a;
   wire tick_b;
   wire b_pulse;

   // second output counts only in the active energy mode
   assign b_pulse = second_converter_output_pulse & active_energy_mode;

   ccr_prescaler u_presc_a (
      .hclk(hclk),
      .hresetn(hresetn),
      .pulse(first_converter_output_pulse),
      .setting(pulse_prescaler_setting),
      .tick(tick_a)
   );

   ccr_prescaler u_presc_b (
      .hclk(hclk),
      .hresetn(hresetn),
      .pulse(b_pulse),
      .setting(pulse_prescaler_setting),
      .tick(tick_b)
   );

   wire rd_take;
   wire cap_a;
   wire cap_b;
   wire [15:0] count_a;
   wire [15:0] count_b;
   wire [7:0] shadow_a;
   wire [7:0] shadow_b;
   wire lost_a;
   wire lost_b;
   wire wrap_a;
   wire wrap_b;

   assign rd_take = take & ~hwrite & aligned;
   assign cap_a = rd_take & (idx == `CCR_IDX_A_HI);
   assign cap_b = rd_take & (idx == `CCR_IDX_B_HI);

   ccr_counter u_cnt_a (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(tick_a),
      .inhibit(inhibit_a),
      .capture_hi(cap_a),
      .count(count_a),
      .shadow(shadow_a),
      .lost(lost_a),
      .wrap(wrap_a)
   );

   ccr_counter u_cnt_b (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(tick_b),
      .inhibit(inhibit_b),
      .capture_hi(cap_b),
      .count(count_b),
      .shadow(shadow_b),
      .lost(lost_b),
      .wrap(wrap_b)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sticky status, cleared by a read, a new event wins over the clear
   reg [3:0] status;
   wire [3:0] events;
   wire stat_rd;

   assign events = {wrap_b, wrap_a, lost_b, lost_a};
   assign stat_rd = rd_take & (idx == `CCR_IDX_STAT);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status <= 4'h0;
      end else if (stat_rd) begin
         status <= events;
      end else begin
         status <= status | events;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, registered at the address phase edge
   reg [7:0] next_byte;

   always @* begin
      next_byte = 8'h00;
      case (idx)
         `CCR_IDX_CTRL: next_byte = {5'h00, pulse_prescaler_setting};
         `CCR_IDX_STAT: next_byte = {3'h0, active_energy_mode, status};
         `CCR_IDX_A_HI: next_byte = count_a[15:8];
         `CCR_IDX_A_LO: next_byte = shadow_a;
         `CCR_IDX_B_HI: next_byte = count_b[15:8];
         `CCR_IDX_B_LO: next_byte = shadow_b;
         default: next_byte = 8'h00;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (rd_take) begin
         hrdata <= {24'h000000, next_byte};
      end else if (take) begin
         hrdata <= 32'h00000000;
      end
   end
endmodule

// *** testbench/ccr_props.sv ***
`timescale 1ns/100ps
module ccr_props (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire active_energy_mode
);
   wire tk = hsel && htrans[1] && hready;
   wire rd = tk && !hwrite && haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0;
   wire [7:0] ix = haddr[9:2];
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ready_high_a: assert property (hreadyout) else $error("not ready");
   resp_okay_a: assert property (!hresp) else $error("bad resp");
   write_clear_a: assert property (tk && hwrite |=> hrdata == 32'h0) else $error("write data");
   byte_only_a: assert property (tk |=> hrdata[31:8] == 24'h0) else $error("upper bits");
   data_hold_a: assert property (!tk |=> $stable(hrdata)) else $error("data moved");
   mode_bit_a: assert property (rd && ix == 8'h11 |=> hrdata[4] == $past(active_energy_mode))
      else $error("mode bit");
   ctrl_width_a: assert property (rd && ix == 8'h10 |=> hrdata[31:3] == 29'h0) else $error("ctrl bits");
   unmapped_a: assert property (rd && (ix < 8'h10 || ix > 8'h16 || ix == 8'h12) |=> hrdata == 32'h0)
      else $error("unmapped");
endmodule
////////////////////////////////////////////////////////////////
bind ccr_top ccr_props i_ccr_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
   .hreadyout, .hresp, .active_energy_mode);

// *** testbench/charge_counter_readout_test.sv ***
`timescale 1ns/100ps
module charge_counter_readout_test;
   reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pa = 0, pb = 0, mode = 0;
   reg [31:0] haddr = 0, hwdata = 0, rd, v, hi_part;
   reg [1:0] htrans = 0;
   wire [31:0] hrdata;
   wire hreadyout;
   integer num_errors = 0, n_checks = 0, i;
   ccr_top i_ccr_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .first_converter_output_pulse(pa),
      .second_converter_output_pulse(pb), .active_energy_mode(mode));
   initial forever #2.5 hclk = ~hclk;
   task report_and_stop;
      begin
         $display("errors %0d checks %0d", num_errors, n_checks);
         if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   task check(input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task bus(input w, input [7:0] ix, input [31:0] wd);
      begin
         @(posedge hclk);
         hsel <= 1;
         haddr <= {22'h0, ix, 2'b00};
         htrans <= 2'b10;
         hwrite <= w;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         hsel <= 0;
         htrans <= 2'b00;
         hwdata <= wd;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         rd = hrdata;
      end
   endtask
   task rchk(input [7:0] ix, input [31:0] exp);
      begin
         bus(0, ix, 0);
         check(rd, exp);
      end
   endtask
   // pulses on alternate cycles, then settle
   task pulse(input integer na, input integer nb);
      for (i = 0; i < 2 * (na + nb) + 4; i = i + 1) begin
         @(posedge hclk);
         pa <= (i % 2 == 0 && i / 2 < na);
         pb <= (i % 2 == 0 && i / 2 < nb);
      end
   endtask
   task t_reset;
      begin
         rchk(8'h13, 0);
         rchk(8'h14, 0);
         rchk(8'h15, 0);
         rchk(8'h16, 0);
         rchk(8'h10, 0);
         bus(1, 8'h13, 32'hff);
         rchk(8'h13, 0);
         rchk(8'h20, 0);
      end
   endtask
   task t_count_a;
      begin
         pulse(300, 0);
         rchk(8'h13, 8'h01);
         pulse(4, 0);
         rchk(8'h14, 8'h2c);
         rchk(8'h13, 8'h01);
         rchk(8'h14, 8'h30);
      end
   endtask
   task t_mode_b;
      begin
         pulse(0, 10);
         @(posedge hclk) mode <= 1;
         pulse(0, 20);
         rchk(8'h15, 0);
         rchk(8'h16, 8'h14);
         rchk(8'h11, 8'h10);
      end
   endtask
   task t_presc;
      begin
         bus(1, 8'h10, 2);
         rchk(8'h10, 2);
         pulse(8, 0);
         rchk(8'h13, 8'h01);
         rchk(8'h14, 8'h32);
         bus(1, 8'h10, 0);
      end
   endtask
   task t_freeze;
      begin
         fork
            pulse(40, 0);
            repeat (6) bus(0, 8'h14, 0);
         join
         rchk(8'h11, 8'h11);
         bus(0, 8'h13, 0);
         v = rd << 8;
         bus(0, 8'h14, 0);
         v = v | rd;
         check(v < 32'h15a, 1);
         pulse(3, 0);
         bus(0, 8'h13, 0);
         hi_part = rd << 8;
         bus(0, 8'h14, 0);
         check(hi_part | rd, v + 3);
      end
   endtask
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1;
      t_reset;
      t_count_a;
      t_mode_b;
      t_presc;
      t_freeze;
      report_and_stop;
   end
   initial begin
      #50000;
      num_errors = num_errors + 1;
      report_and_stop;
   end
endmodule
